// ---- design/hppc_pkg.sv ----
package hppc_pkg;

  // Register offsets of the configuration map
  localparam logic [7:0] OFS_REMOVABILITY_MAP = 8'h09;
  localparam logic [7:0] OFS_PORT_OFF_SELF    = 8'h0A;
  localparam logic [7:0] OFS_PORT_OFF_BUS     = 8'h0B;
  localparam logic [7:0] OFS_DRAW_SELF        = 8'h0C;
  localparam logic [7:0] OFS_DRAW_BUS         = 8'h0D;

  // Reset values of every register
  localparam logic [7:0] RST_REG = 8'h00;

  // Bit 0 of each port map is reserved; ports live in bits 7:1
  localparam logic [7:0] PORT_BITS_MASK = 8'hFE;

  // Draw scale: one count is this many mA
  localparam int unsigned DRAW_MA_PER_LSB = 2;

  // Answer for any undefined offset
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Register access request from the configuration host
  typedef struct packed {
    logic       wr_en;   // One-cycle write strobe
    logic [7:0] addr;    // Register offset
    logic [7:0] wdata;   // Write data
  } hppc_req_s;

  // Power mode bits: three choose the active register set, one flags a compound device
  typedef struct packed {
    logic power_source_select; // 1 = self-powered, 0 = bus-powered
    logic dynamic_en;          // Local supply sense decides when set
    logic local_supply_sense;  // 1 = local supply present
    logic compound_en;         // Hub is part of a compound device
  } hppc_mode_s;

endpackage : hppc_pkg

// ---- design/hppc_regs.sv ----
`timescale 1ns/10ps
module hppc_regs (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  // Register access from the configuration host
  input  wire hppc_pkg::hppc_req_s   req_i,
  output logic [7:0]                 rdata_o,
  // Power mode controls from the configuration bytes and pins
  input  wire hppc_pkg::hppc_mode_s  mode_i,
  // Hub core view
  output logic                       self_powered_o,
  output logic                       compound_o,
  output logic [7:1]                 port_off_o,
  output logic [7:1]                 removability_map_o,
  output logic [7:0]                 draw_o,
  output logic [9:0]                 draw_ma_o
);
  import hppc_pkg::*;

  // All five registers sit on one clock and one synchronous reset.
  // The write decode compares the full offset, so aliases cannot land.
  // Each register but the two draws, which share one, has its own process, which keeps the strobe fan-out local
  // and makes a missed offset easy to spot in a waveform.
  // No register has a side effect on read.
  // Stored registers, then the combinational source choice and read mux result
  logic [7:0] removability_map;   // Non-removable flags
  logic [7:0] port_off_self;      // Self-powered disable mask
  logic [7:0] port_off_bus;       // Bus-powered disable mask
  logic [7:0] draw_self;          // Self-powered upstream draw
  logic [7:0] draw_bus;           // Bus-powered upstream draw
  logic       self_sel;           // Active power source
  logic [7:0] next_rdata;         // Read mux result

  // The hub core only ever sees bits 7:1; bit 0 never leaves this block.
  // A host that writes a one there reads back zero, which is intended.
  // Removability map; bit 0 forced to zero so it cannot hold a one
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      removability_map <= RST_REG;
    end else if (req_i.wr_en && req_i.addr == OFS_REMOVABILITY_MAP) begin
      removability_map <= req_i.wdata & PORT_BITS_MASK;
    end
  end

  // Used only while the active power source is the local supply.
  // A bad, non-contiguous mask is passed on as written.
  // Self-powered disable mask, reserved bit dropped on write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      port_off_self <= RST_REG;
    end else if (req_i.wr_en && req_i.addr == OFS_PORT_OFF_SELF) begin
      port_off_self <= req_i.wdata & PORT_BITS_MASK;
    end
  end

  // Used only while the hub draws its power from upstream.
  // Reset leaves every port available in both modes.
  // Bus-powered disable mask; contiguity is the host's duty, not checked here
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      port_off_bus <= RST_REG;
    end else if (req_i.wr_en && req_i.addr == OFS_PORT_OFF_BUS) begin
      port_off_bus <= req_i.wdata & PORT_BITS_MASK;
    end
  end

  // Both counts are plain unsigned bytes in 2 mA steps, no offset.
  // Nothing here limits the self-powered value; keeping it low is up to
  // the host, since a clamp would hide a wrong configuration.
  // Writes to both draws may come in back-to-back cycles.
  // Draw registers; the host must already fold in compound peripheral current
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      draw_self <= RST_REG;
      draw_bus  <= RST_REG;
    end else if (req_i.wr_en) begin
      if (req_i.addr == OFS_DRAW_SELF) begin
        draw_self <= req_i.wdata;
      end
      if (req_i.addr == OFS_DRAW_BUS) begin
        draw_bus <= req_i.wdata;
      end
    end
  end

  // Combinational on purpose: the result is used four times below and is
  // registered there, so a glitch on the pins never reaches the core.
  // Pins are taken as synchronous to ref_clk_i.
  // Power source choice: dynamic switching hands it to the sense pin
  always_comb begin
    if (mode_i.dynamic_en) begin
      self_sel = mode_i.local_supply_sense;
    end else begin
      self_sel = mode_i.power_source_select;
    end
  end

  // The address is decoded every cycle, whether or not a write is made.
  // A write and a read of the same offset in one cycle return the old value;
  // the new value shows one cycle later.
  // Undefined offsets answer zero and ignore writes.
  // Read mux; undefined offsets answer zero
  always_comb begin
    case (req_i.addr)
      OFS_REMOVABILITY_MAP: next_rdata = removability_map;
      OFS_PORT_OFF_SELF:    next_rdata = port_off_self;
      OFS_PORT_OFF_BUS:     next_rdata = port_off_bus;
      OFS_DRAW_SELF:        next_rdata = draw_self;
      OFS_DRAW_BUS:         next_rdata = draw_bus;
      default:              next_rdata = RD_UNMAPPED;
    endcase
  end

  // Costs a cycle of latency but keeps the output free of decode glitches.
  // Reset value is zero, like the registers.
  // The address is held by the host for as long as it wants the data.
  // Read data registered so it is stable one cycle after the address
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= RST_REG;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // A mode change reaches the core at the edge that samples it, a register write
  // one edge after it is stored, so the core never sees a mix of two modes.
  // The mA value is worked out here to spare the core a multiplier.
  // Bit n of port_off_o is downstream port n.
  // Hub core outputs; registered so mode flips settle in one edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      self_powered_o     <= 1'b0;
      compound_o         <= 1'b0;
      port_off_o         <= '0;
      removability_map_o <= '0;
      draw_o             <= RST_REG;
      draw_ma_o          <= '0;
    end else begin
      self_powered_o     <= self_sel;
      compound_o         <= mode_i.compound_en;
      removability_map_o <= removability_map[7:1];
      port_off_o         <= self_sel ? port_off_self[7:1] : port_off_bus[7:1];
      draw_o             <= self_sel ? draw_self : draw_bus;
      // Linear scale with no offset: 50 counts gives 100 mA
      draw_ma_o          <= 10'(DRAW_MA_PER_LSB) * {2'b00, (self_sel ? draw_self : draw_bus)};
    end
  end

  // Read-back, reset and output checks follow.
  // Every check is off during reset except the reset checks themselves,
  // which look at the cycle just after reset is seen.
  // Reads are checked against the stored registers of the previous cycle,
  // since rdata_o is registered.
  // Checks next to the logic they guard
  a_reserved_bit_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    removability_map[0] == 1'b0 && port_off_self[0] == 1'b0 && port_off_bus[0] == 1'b0)
    else $error("reserved bit 0 holds a one");

  a_reset_clears_regs: assert property (@(posedge ref_clk_i)
    !rst_b_i |=> (removability_map == 8'h00 && port_off_self == 8'h00 && port_off_bus == 8'h00
                  && draw_self == 8'h00 && draw_bus == 8'h00))
    else $error("register not cleared by reset");

  a_self_mask_used: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    self_sel |=> (port_off_o == $past(port_off_self[7:1]) || !rst_b_i))
    else $error("self-powered mask not applied");

  a_bus_mask_used: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !self_sel |=> port_off_o == $past(port_off_bus[7:1]))
    else $error("bus-powered mask not applied");

  a_draw_scale_ma: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 draw_ma_o == {1'b0, draw_o, 1'b0})
    else $error("draw mA not twice the count");

  a_draw_self_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (req_i.wr_en && req_i.addr == OFS_DRAW_SELF && mode_i.dynamic_en == 1'b0
     && mode_i.power_source_select) ##1 $stable(mode_i) && !req_i.wr_en
    |=> draw_o == $past(req_i.wdata, 2))
    else $error("self draw not reported");

  a_draw_bus_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (req_i.wr_en && req_i.addr == OFS_DRAW_BUS && !self_sel) ##1 (!self_sel && !req_i.wr_en)
    |=> draw_o == $past(req_i.wdata, 2))
    else $error("bus draw not reported");

  a_dynamic_sense: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mode_i.dynamic_en |=> self_powered_o == $past(mode_i.local_supply_sense))
    else $error("dynamic mode ignores sense pin");

  a_static_select: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !mode_i.dynamic_en |=> self_powered_o == $past(mode_i.power_source_select))
    else $error("select bit not followed");

  a_compound_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 compound_o == $past(mode_i.compound_en))
    else $error("compound flag mismatch");

  a_removable_map: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (req_i.wr_en && req_i.addr == OFS_REMOVABILITY_MAP) ##1 !req_i.wr_en
    |=> removability_map_o == $past(req_i.wdata[7:1], 2))
    else $error("removability map not reported");

  // Read of the removability map returns the stored byte
  a_read_nr_map: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_i.addr == OFS_REMOVABILITY_MAP
    |=> rdata_o == $past(removability_map))
    else $error("removability map read wrong");

  // Read of the self-powered mask returns the stored byte
  a_read_self_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_i.addr == OFS_PORT_OFF_SELF
    |=> rdata_o == $past(port_off_self))
    else $error("self mask read wrong");

  // Read of the bus-powered mask returns the stored byte
  a_read_bus_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_i.addr == OFS_PORT_OFF_BUS
    |=> rdata_o == $past(port_off_bus))
    else $error("bus mask read wrong");

  // Read of the self-powered draw returns the stored byte
  a_read_draw_self: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_i.addr == OFS_DRAW_SELF
    |=> rdata_o == $past(draw_self))
    else $error("self draw read wrong");

  // Read of the bus-powered draw returns the stored byte
  a_read_draw_bus: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_i.addr == OFS_DRAW_BUS
    |=> rdata_o == $past(draw_bus))
    else $error("bus draw read wrong");

  // Reserved bit of the removability map always reads zero
  a_read_bit0_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_i.addr == OFS_REMOVABILITY_MAP
    |=> rdata_o[0] == 1'b0)
    else $error("reserved bit read as one");

  // Self-powered mA value is twice the stored count
  a_self_draw_ma: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    self_sel
    |=> draw_ma_o == {1'b0, $past(draw_self), 1'b0})
    else $error("self draw mA wrong");

  // Bus-powered mA value is twice the stored count
  a_bus_draw_ma: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !self_sel
    |=> draw_ma_o == {1'b0, $past(draw_bus), 1'b0})
    else $error("bus draw mA wrong");

  // Fifty counts read out as 100 mA
  a_fifty_counts: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    self_sel && draw_self == 8'h32
    |=> draw_ma_o == 10'h064)
    else $error("fifty counts not 100 mA");

  // Core outputs are cleared by reset
  a_reset_outputs: assert property (@(posedge ref_clk_i)
    !rst_b_i
    |=> draw_o == 8'h00 && draw_ma_o == 10'h000 && port_off_o == 7'h00 && removability_map_o == 7'h00)
    else $error("outputs not cleared by reset");

  // Self-powered draw is the one reported while self-powered
  a_self_draw_out: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    self_sel
    |=> draw_o == $past(draw_self))
    else $error("self draw not selected");

  // Bus-powered draw is the one reported while bus-powered
  a_bus_draw_out: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !self_sel
    |=> draw_o == $past(draw_bus))
    else $error("bus draw not selected");

  // Port flags follow the stored map one edge later
  a_port_map_out: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    1'b1
    |=> removability_map_o == $past(removability_map[7:1]))
    else $error("port flags not forwarded");

  // Active power source flag follows the selection
  a_self_flag_out: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    1'b1
    |=> self_powered_o == $past(self_sel))
    else $error("power source flag wrong");

endmodule : hppc_regs

// ---- bench/hppc_cfg_host.sv ----
`timescale 1ns/10ps
module hppc_cfg_host (
  // Clock and read data
  input  wire logic          ref_clk_i,
  input  wire logic [7:0]    rdata_i,
  // Register request
  output hppc_pkg::hppc_req_s req_o
);
  import hppc_pkg::*;
  // Idle: no strobe until the bench asks
  initial req_o = '0;
  // One-cycle write; masks handed in are contiguous groups
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req_o <= '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req_o.wr_en <= 1'b0;
    // Stale data is inverted so nothing leans on it
    req_o.wdata <= ~d;
  endtask : wr
  // Present the offset, then take data two sampled edges later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    req_o.addr <= a;
    repeat (2) @(posedge ref_clk_i);
    #1 d = rdata_i;
  endtask : rd
endmodule : hppc_cfg_host

// ---- bench/tb_hub_port_power_config_regs.sv ----
`timescale 1ns/10ps
module tb_hub_port_power_config_regs;
  import hppc_pkg::*;
  logic       ref_clk_i = 1'b0; // 4 ns clock
  logic       rst_b_i   = 1'b0; // Held low at start
  hppc_req_s  req;              // From host model
  hppc_mode_s mode      = '0;   // Power mode pins
  logic [7:0] rdata, draw, d;
  logic       self_pw, cmpd;
  logic [7:1] port_off, nr_map;
  logic [9:0] draw_ma;
  int         mismatches = 0;
  int         n_checks   = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  hppc_cfg_host i_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req));
  hppc_regs i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req), .rdata_o(rdata),
    .mode_i(mode), .self_powered_o(self_pw), .compound_o(cmpd), .port_off_o(port_off),
    .removability_map_o(nr_map), .draw_o(draw), .draw_ma_o(draw_ma));
  // Compare one value of up to 10 bits
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Mode pins change at an edge; outputs follow one edge later
  task automatic set_mode(input logic s, input logic dy, input logic sn, input logic c);
    @(posedge ref_clk_i);
    mode <= '{power_source_select: s, dynamic_en: dy, local_supply_sense: sn, compound_en: c};
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : set_mode
  // Every register and the draw, port-off and map outputs clear
  task automatic t_reset();
    for (int a = 9; a <= 13; a++) begin
      i_host.rd(8'(a), d);
      chk("reg", 10'h000, {2'b00, d});
    end
    chk("outs", 10'h000, {2'b00, draw} | draw_ma | {3'b000, port_off});
    chk("nr_map_rst", 10'h000, {3'b000, nr_map});
    $display("t_reset done");
  endtask : t_reset
  // Reserved bit 0 dropped, ports kept
  task automatic t_removable();
    i_host.wr(OFS_REMOVABILITY_MAP, 8'hFF);
    i_host.rd(OFS_REMOVABILITY_MAP, d);
    chk("nr_reg", 10'h0FE, {2'b00, d});
    chk("nr_map", 10'h07F, {3'b000, nr_map});
    $display("t_removable done");
  endtask : t_removable
  // Disable masks follow the selected power source
  task automatic t_port_off();
    i_host.wr(OFS_PORT_OFF_SELF, 8'h0F);
    i_host.wr(OFS_PORT_OFF_BUS, 8'hF0);
    i_host.rd(OFS_PORT_OFF_SELF, d);
    chk("off_self_reg", 10'h00E, {2'b00, d});
    set_mode(1'b1, 1'b0, 1'b0, 1'b0);
    chk("off_self", 10'h007, {3'b000, port_off});
    set_mode(1'b0, 1'b0, 1'b1, 1'b0);
    chk("off_bus", 10'h078, {3'b000, port_off});
    set_mode(1'b0, 1'b1, 1'b1, 1'b0);
    chk("dyn_self", 10'h001, {9'h000, self_pw});
    $display("t_port_off done");
  endtask : t_port_off
  // Draw in 2 mA counts, unmapped offset, then reset again
  task automatic t_draw();
    i_host.wr(OFS_DRAW_SELF, 8'h32);
    i_host.wr(OFS_DRAW_BUS, 8'hFA);
    set_mode(1'b1, 1'b0, 1'b0, 1'b1);
    chk("draw_ma_self", 10'd100, draw_ma);
    chk("draw_self", 10'h032, {2'b00, draw});
    chk("compound", 10'h001, {9'h000, cmpd});
    set_mode(1'b0, 1'b0, 1'b0, 1'b0);
    chk("draw_ma_bus", 10'd500, draw_ma);
    chk("draw_bus", 10'h0FA, {2'b00, draw});
    i_host.rd(OFS_DRAW_SELF, d);
    chk("draw_self_reg", 10'h032, {2'b00, d});
    i_host.wr(8'h0E, 8'hAA);
    i_host.rd(8'h0E, d);
    chk("unmapped", 10'h000, {2'b00, d});
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    i_host.rd(OFS_DRAW_BUS, d);
    chk("draw_rst", 10'h000, {2'b00, d});
    chk("draw_o_rst", 10'h000, {2'b00, draw});
    $display("t_draw done");
  endtask : t_draw
  // Counts, then the verdict
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // Whole run needs well under 5000 cycles
  initial begin
    #20000;
    mismatches++;
    results();
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_removable();
    t_port_off();
    t_draw();
    results();
  end
endmodule : tb_hub_port_power_config_regs
